// file: dma_req_cfg.svh
// Register offsets, field positions, reset values and counts
// for the request sampling and transfer-end block.
// Assumes an 8-bit word address space on the plain register port.
`ifndef DMA_REQ_CFG_SVH
`define DMA_REQ_CFG_SVH

// =====================================================
// Register offsets
`define OFF_CTRL   8'h00
`define OFF_OPER   8'h04
`define OFF_SRC    8'h08
`define OFF_DST    8'h0c
`define OFF_COUNT  8'h10
`define OFF_STAT   8'h14
`define OFF_MASK   8'h18
`define OFF_WAIT   8'h1c

// =====================================================
// Field positions
`define CTRL_EN    0
`define CTRL_IE    1
`define CTRL_BURST 2
`define CTRL_DUAL  3
`define CTRL_EDGE  4
`define CTRL_TE    5
`define OPER_DME   0
`define OPER_NMI_HALT_FLAG  1
`define OPER_AEF   2
`define EV_TE      0
`define EV_NMI     1
`define EV_AE      2
`define WAIT_DUAL_LO   0
`define WAIT_SINGLE_LO 4

// =====================================================
// Reset values and counts
`define RST_WORD   32'h0000_0000
`define RST_COUNT  16'h0000
`define RST_WAIT   8'h00
`define RST_EV     3'h0
`define COUNT_LAST 16'h0001
`define WCNT_ZERO  4'h0

`endif

// file: dma_req_pkg.sv
// Types shared by the request sampling and transfer-end block.
// Assumes the constants of dma_req_cfg.svh are included where needed.
package dma_req_pkg;

    // Bus cycle sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_LEAD   = 3'b001,
        ST_READ   = 3'b010,
        ST_WRITE  = 3'b011,
        ST_SINGLE = 3'b100
    } bus_state_t;

    // Request pin sampling modes.
    typedef enum logic [2:0] {
        SM_EVERY = 3'b000,
        SM_HOLD  = 3'b001,
        SM_ACK   = 3'b010,
        SM_BOUND = 3'b011,
        SM_NONE  = 3'b100
    } smp_mode_t;

endpackage

// file: dma_req_end.sv
// One external-request DMA channel: request pin sampling, bus cycle
// sequencing with wait states, and per-channel and global transfer end.
// Assumes it owns the bus whenever bus_own is high and that inputs are
// synchronous to clk apart from the request pin, which is synchronised.
//
// Behaviour
// - Bus cycle length follows wait fields: dual uses first, single second.
// - Request sampled before clock rise; DMA cycle starts two states later.
// - Cycle steal samples alike for edge and level; edge seen once only.
// - After cycle steal detect, next sample waits for first acknowledge state.
// - If that sample misses, sample next acknowledge state, then every state.
// - Burst edge: after falling edge transfer to end, pin ignored.
// - Burst edge: after end, sample every state until transfer-end cleared.
// - Burst level single: sample at end of each CPU or DMA cycle.
// - Burst level dual: sample at start of each DMA read cycle.
// - Burst level: boundary sample miss means sampling every state after.
// - Count reaching zero sets transfer-end flag and interrupt if enabled.
// - Clearing channel enable halts channel without transfer-end flag.
// - NMI or address error sets its flag, stops all, keeps registers.
// - Restart only after flag cleared and channel enable set.
// - Dual address error in read completes following write, updates, halts.
// - Clearing master enable aborts at cycle end without transfer-end flag.
// - Burst low level: request high releases bus after current cycle.
// - Cycle steal returns bus after each unit, reacquires per request.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "dma_req_cfg.svh"

module dma_req_end
    import dma_req_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Requester pins
    input  wire logic        dma_request_pin_n,
    output logic             dma_acknowledge_pin_n,
    // System events
    input  wire logic        nmi_event,
    input  wire logic        address_error,
    input  wire logic        cpu_cycle_end,
    // Bus cycle outputs
    output logic             bus_own,
    output logic             cycle_active,
    output logic             cycle_write,
    output logic      [31:0] cycle_addr,
    // Interrupts
    output logic             dma_end_interrupt,
    output logic             irq
);

    // =====================================================
    // State
    bus_state_t  state, next_state;
    smp_mode_t   smode, next_smode;
    logic        req_s1, req_s2, req_prev;
    logic        pend, next_pend;
    logic        first, next_first;
    logic [3:0]  wcnt, next_wcnt;
    logic        ae_finish, next_ae_finish;
    logic        en, ie, burst, dual, edge_mode, te;
    logic        next_en, next_ie, next_burst, next_dual, next_edge_mode, next_te;
    logic        master_dma_enable, nmi_halt_flag, aef, next_dme, next_nmi_halt_flag, next_aef;
    logic [31:0] src, dst, next_src, next_dst;
    logic [15:0] count, next_count;
    logic [7:0]  wait_ctrl, next_wait_ctrl;
    logic [2:0]  stat, mask, next_stat, next_mask;
    logic [31:0] next_rdata;

    // Decoded conditions
    logic        detect, in_cycle, ack, cycle_end, sample_now, hit;
    logic        run_ok, stop, ae_now, ae_hold, xfer_done, last;
    logic [3:0]  wait_load;
    logic        te_set, nmi_set, ae_set;
    logic        wr_ctrl, wr_oper, wr_stat;

    // =====================================================
    // Decode
    // edge versus level
    assign detect    = edge_mode ? (req_s2 & ~req_prev) : req_s2;
    assign in_cycle  = (state == ST_READ) || (state == ST_WRITE) || (state == ST_SINGLE);
    assign ack       = (state == ST_READ) || (state == ST_SINGLE);
    assign cycle_end = in_cycle && (wcnt == `WCNT_ZERO);
    assign wait_load = dual ? wait_ctrl[`WAIT_DUAL_LO +: 4] : wait_ctrl[`WAIT_SINGLE_LO +: 4];
    assign run_ok    = en && master_dma_enable && !nmi_halt_flag && !aef && !te;
    assign ae_now    = address_error && in_cycle;
    assign ae_hold   = ae_finish || (ae_now && state == ST_READ);
    assign stop      = !en || nmi_halt_flag || nmi_event || ((aef || ae_now) && !ae_hold);
    assign last      = (count == `COUNT_LAST);
    assign xfer_done = cycle_end && (state == ST_WRITE || state == ST_SINGLE) && !stop;
    assign te_set    = xfer_done && last && master_dma_enable; // no end flag after master disable.
    assign nmi_set   = nmi_event;
    assign ae_set    = ae_now;
    assign wr_ctrl   = reg_write && reg_addr == `OFF_CTRL;
    assign wr_oper   = reg_write && reg_addr == `OFF_OPER;
    assign wr_stat   = reg_write && reg_addr == `OFF_STAT;
    assign hit       = sample_now && detect;

    // Sample points per mode; the pin is only looked at where this is high.
    always_comb begin
        unique case (smode)
            SM_EVERY: sample_now = 1'b1;
            SM_HOLD:  sample_now = ack && first;
            SM_ACK:   sample_now = ack && !first;
            SM_BOUND: sample_now = dual ? (state == ST_READ && first)
                                        : ((state == ST_SINGLE && cycle_end) || cpu_cycle_end);
            SM_NONE:  sample_now = 1'b0;
            default:  sample_now = 1'b0;
        endcase
    end

    // =====================================================
    // Register file next values
    // Status flags are write-one-to-clear and a set in the same cycle wins.
    always_comb begin
        next_en        = en;
        next_ie        = ie;
        next_burst     = burst;
        next_dual      = dual;
        next_edge_mode = edge_mode;
        next_dme       = master_dma_enable;
        next_wait_ctrl = wait_ctrl;
        next_mask      = mask;
        if (wr_ctrl) begin
            next_en        = reg_wdata[`CTRL_EN];
            next_ie        = reg_wdata[`CTRL_IE];
            next_burst     = reg_wdata[`CTRL_BURST];
            next_dual      = reg_wdata[`CTRL_DUAL];
            next_edge_mode = reg_wdata[`CTRL_EDGE];
        end
        if (wr_oper) begin
            next_dme = reg_wdata[`OPER_DME];
        end
        if (reg_write && reg_addr == `OFF_WAIT) begin
            next_wait_ctrl = reg_wdata[7:0];
        end
        if (reg_write && reg_addr == `OFF_MASK) begin
            next_mask = reg_wdata[2:0];
        end
        next_te   = (te & ~(wr_ctrl & reg_wdata[`CTRL_TE])) | te_set;
        next_nmi_halt_flag = (nmi_halt_flag & ~(wr_oper & reg_wdata[`OPER_NMI_HALT_FLAG])) | nmi_set;
        next_aef  = (aef & ~(wr_oper & reg_wdata[`OPER_AEF])) | ae_set;
        next_stat = (stat & ~({3{wr_stat}} & reg_wdata[2:0])) | {ae_set, nmi_set, te_set};
        // Read data stands only in the cycle after the strobe.
        next_rdata = 32'h0000_0000;
        if (reg_read) begin
            unique case (reg_addr)
                `OFF_CTRL:  next_rdata = {26'h0, te, edge_mode, dual, burst, ie, en};
                `OFF_OPER:  next_rdata = {29'h0, aef, nmi_halt_flag, master_dma_enable};
                `OFF_SRC:   next_rdata = src;
                `OFF_DST:   next_rdata = dst;
                `OFF_COUNT: next_rdata = {16'h0, count};
                `OFF_STAT:  next_rdata = {29'h0, stat};
                `OFF_MASK:  next_rdata = {29'h0, mask};
                `OFF_WAIT:  next_rdata = {24'h0, wait_ctrl};
                default:    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // =====================================================
    // Sampling and sequencer next values
    always_comb begin
        next_smode     = smode;
        next_pend      = pend;
        next_state     = state;
        next_wcnt      = wcnt;
        next_first     = 1'b0;
        next_ae_finish = ae_finish || (ae_now && state == ST_READ);
        next_src       = src;
        next_dst       = dst;
        next_count     = count;
        // Software loads addresses and count; a unit completing in the same cycle wins.
        if (reg_write && reg_addr == `OFF_SRC) begin
            next_src = reg_wdata;
        end
        if (reg_write && reg_addr == `OFF_DST) begin
            next_dst = reg_wdata;
        end
        if (reg_write && reg_addr == `OFF_COUNT) begin
            next_count = reg_wdata[15:0];
        end
        // Sampling outcome.
        if (hit) begin
            next_pend  = 1'b1;
            next_smode = burst ? (edge_mode ? SM_NONE : SM_BOUND) : SM_HOLD;
        end else if (sample_now) begin
            unique case (smode)
                SM_HOLD: next_smode = SM_ACK;
                SM_ACK:  next_smode = SM_EVERY;
                SM_BOUND: begin
                    next_smode = SM_EVERY;
                    next_pend  = 1'b0;
                end
                default: next_smode = smode;
            endcase
        end else if (smode == SM_ACK && state == ST_IDLE) begin
            // idle fallback: no acknowledge state can come without a request, so avoid a hang.
            next_smode = SM_EVERY;
        end
        // Sequencer.
        if (stop && state != ST_IDLE) begin
            // halt with registers as last completed
            next_state = ST_IDLE;
            next_pend  = 1'b0;
            next_smode = SM_EVERY;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_ae_finish = 1'b0;
                    // disabled channel forgets requests, so no stale start on enable.
                    if (!en) begin
                        next_pend  = 1'b0;
                        next_smode = SM_EVERY;
                    end
                    // one lead state, cycle two states after detect
                    if ((pend || hit) && run_ok) begin
                        next_state = ST_LEAD;
                        if (!burst) begin
                            next_pend = 1'b0;
                        end
                    end
                end
                ST_LEAD: begin
                    next_state = dual ? ST_READ : ST_SINGLE;
                    next_wcnt  = wait_load;
                    next_first = 1'b1;
                end
                ST_READ: begin
                    next_wcnt = wcnt - 4'h1;
                    if (cycle_end) begin
                        // abort at end of current cycle
                        next_state = master_dma_enable ? ST_WRITE : ST_IDLE;
                        next_wcnt  = wait_load;
                        next_first = 1'b1;
                    end
                end
                ST_WRITE, ST_SINGLE: begin
                    next_wcnt = wcnt - 4'h1;
                    if (cycle_end) begin
                        next_src   = src + 32'h1;
                        next_dst   = dual ? dst + 32'h1 : dst;
                        next_count = count - 16'h1;
                        next_state = ST_IDLE;
                        if (last) begin
                            // sample every state after the end
                            next_pend  = 1'b0;
                            next_smode = SM_EVERY;
                        end else if (burst && run_ok && !ae_finish
                                     && (edge_mode || next_pend)) begin
                            next_state = dual ? ST_READ : ST_SINGLE;
                            next_wcnt  = wait_load;
                            next_first = 1'b1;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    // =====================================================
    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1    <= 1'b0;
            req_s2    <= 1'b0;
            req_prev  <= 1'b0;
            state     <= ST_IDLE;
            smode     <= SM_EVERY;
            pend      <= 1'b0;
            first     <= 1'b0;
            wcnt      <= `WCNT_ZERO;
            ae_finish <= 1'b0;
            en        <= 1'b0;
            ie        <= 1'b0;
            burst     <= 1'b0;
            dual      <= 1'b0;
            edge_mode <= 1'b0;
            te        <= 1'b0;
            master_dma_enable       <= 1'b0;
            nmi_halt_flag      <= 1'b0;
            aef       <= 1'b0;
            src       <= `RST_WORD;
            dst       <= `RST_WORD;
            count     <= `RST_COUNT;
            wait_ctrl <= `RST_WAIT;
            stat      <= `RST_EV;
            mask      <= `RST_EV;
            reg_rdata <= `RST_WORD;
        end else begin
            req_s1    <= ~dma_request_pin_n;
            req_s2    <= req_s1;
            req_prev  <= req_s2;
            state     <= next_state;
            smode     <= next_smode;
            pend      <= next_pend;
            first     <= next_first;
            wcnt      <= next_wcnt;
            ae_finish <= next_ae_finish;
            en        <= next_en;
            ie        <= next_ie;
            burst     <= next_burst;
            dual      <= next_dual;
            edge_mode <= next_edge_mode;
            te        <= next_te;
            master_dma_enable       <= next_dme;
            nmi_halt_flag      <= next_nmi_halt_flag;
            aef       <= next_aef;
            src       <= next_src;
            dst       <= next_dst;
            count     <= next_count;
            wait_ctrl <= next_wait_ctrl;
            stat      <= next_stat;
            mask      <= next_mask;
            reg_rdata <= next_rdata;
        end
    end

    // =====================================================
    // Outputs
    // Acknowledge marks the read cycle in dual mode, the whole cycle in single.
    assign dma_acknowledge_pin_n = ~ack;
    assign bus_own      = state != ST_IDLE;
    assign cycle_active = in_cycle;
    assign cycle_write  = state == ST_WRITE;
    assign cycle_addr   = (state == ST_WRITE) ? dst : src;
    assign dma_end_interrupt = te && ie;
    assign irq          = |(stat & mask);

    // =====================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    lead_gap_a: assert property (in_cycle && !$past(in_cycle) |-> $past(state) == ST_LEAD)
        else $error("bus cycle started without lead state");
    start_two_a: assert property (state == ST_IDLE && hit && run_ok && !stop
        |=> state == ST_LEAD ##1 (state == ST_READ || state == ST_SINGLE || !en || nmi_halt_flag || aef))
        else $error("cycle not two states after detect");
    wait_len_a: assert property (state == ST_LEAD && !stop |=> wcnt == $past(wait_load))
        else $error("cycle length ignores wait field");
    edge_once_a: assert property (edge_mode && hit |-> req_s2 && !req_prev)
        else $error("edge request taken without new edge");
    hold_quiet_a: assert property (smode == SM_HOLD && !(ack && first) |-> !sample_now)
        else $error("sampled while suspended");
    burst_edge_a: assert property (smode == SM_NONE |-> !sample_now)
        else $error("pin sampled during edge burst");
    bound_miss_a: assert property (smode == SM_BOUND && sample_now && !detect
        |=> smode == SM_EVERY && !pend)
        else $error("boundary miss not handled");
    te_irq_a: assert property (te_set |=> te ##0 dma_end_interrupt == ie)
        else $error("transfer end flag not raised");
    en_halt_a: assert property (!en && state != ST_IDLE |=> state == ST_IDLE && !$rose(te))
        else $error("disabled channel kept running");
    nmi_stop_a: assert property (nmi_halt_flag |=> state == ST_IDLE)
        else $error("channel ran with halt flag set");
    ae_write_a: assert property (ae_hold && state == ST_READ && cycle_end && en && master_dma_enable && !nmi_halt_flag && !nmi_event
        |=> state == ST_WRITE)
        else $error("write after address error skipped");
    dme_abort_a: assert property (!master_dma_enable && cycle_end |=> state == ST_IDLE && !$rose(te))
        else $error("master disable did not abort");
    steal_rel_a: assert property (!burst && xfer_done |=> state == ST_IDLE)
        else $error("cycle steal kept the bus");

    steal_cov: cover property (!burst && state == ST_LEAD ##[1:40] !burst && xfer_done);
    burst_cov: cover property (burst && !edge_mode && xfer_done ##1 in_cycle);
    ae_cov: cover property (ae_now && state == ST_READ ##[1:20] state == ST_WRITE);
    end_cov: cover property (te_set);

endmodule

// file: dma_requester.sv
// Requester model for the request and acknowledge pins.
// Assumes acknowledge is active low and synchronous to clk.
`timescale 1ns/10ps
module dma_requester (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bench control
    input  wire logic req_on,
    input  wire logic pulse_mode,
    // Pins
    input  wire logic dma_acknowledge_pin_n,
    output logic      dma_request_pin_n
);
    logic       ack_q;
    logic [1:0] gap;

    // ==========================================
    // Pin driver
    // Pulse mode lifts the pin after each unit, so every unit gets a fresh edge.
    // request level control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q             <= 1'b1;
            gap               <= 2'h0;
            dma_request_pin_n <= 1'b1;
        end else begin
            ack_q <= dma_acknowledge_pin_n;
            if (pulse_mode && !ack_q && dma_acknowledge_pin_n) begin
                gap <= 2'h3;
            end else if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end
            dma_request_pin_n <= !(req_on && gap == 2'h0);
        end
    end
endmodule

// file: dma_request_sampling_and_end_tb_top.sv
// Self-checking bench for the request sampling and transfer-end block.
// Assumes the requester model drives the request pin; clock is 250 MHz.
`timescale 1ns/10ps
`include "dma_req_cfg.svh"
module dma_request_sampling_and_end_tb_top;
    logic        clk, rst_n, reg_write, reg_read, pin_n, ack_n;
    logic        nmi_event, address_error, cpu_cycle_end, bus_own;
    logic        cycle_active, cycle_write, dma_end_interrupt, irq;
    logic        req_on, pulse_mode, own_q;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, cycle_addr, seed, v, s, d, a0;
    int          error_cnt, n_tests, ack_cyc, own_rise, tick, act_cyc, wr_cyc;
    logic [31:0] modes [6] = '{32'h00, 32'h18, 32'h14, 32'h0c, 32'h04, 32'h10};
    logic [7:0]  rst_a [7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};

    dma_req_end dma_req_end_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .dma_request_pin_n(pin_n), .dma_acknowledge_pin_n(ack_n),
        .nmi_event(nmi_event), .address_error(address_error),
        .cpu_cycle_end(cpu_cycle_end), .bus_own(bus_own), .cycle_active(cycle_active),
        .cycle_write(cycle_write), .cycle_addr(cycle_addr),
        .dma_end_interrupt(dma_end_interrupt), .irq(irq));
    dma_requester dma_requester_inst (
        .clk(clk), .rst_n(rst_n), .req_on(req_on), .pulse_mode(pulse_mode),
        .dma_acknowledge_pin_n(ack_n), .dma_request_pin_n(pin_n));

    // ==========================================
    // Clock, monitor and helpers
    always #2 clk = ~clk;

    // Counts acknowledge, cycle and write states and bus grabs; CPU cycle ends come every 8 cycles.
    always @(posedge clk) begin
        own_q <= bus_own;
        tick <= tick + 1;
        cpu_cycle_end <= (tick % 8 == 0);
        if (ack_n === 1'b0 && ack_cyc == 0) a0 = cycle_addr;
        if (ack_n === 1'b0) ack_cyc++;
        if (cycle_active === 1'b1) act_cyc++;
        if (cycle_write === 1'b1) wr_cyc++;
        if (bus_own === 1'b1 && own_q === 1'b0) own_rise++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= dat;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dat);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
        dat = reg_rdata;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wait_ack();
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            if (ack_n === 1'b0) break;
        end
    endtask

    task automatic wait_te();
        for (int i = 0; i < 150; i++) begin
            rd(`OFF_CTRL, v);
            if (v[`CTRL_TE] === 1'b1) break;
        end
    endtask

    // One complete transfer in the given mode with random addresses, waits and count.
    task automatic run(input logic [31:0] ctl);
        logic [7:0]  w;
        logic [15:0] n;
        int          sel;
        w = 8'(rnd()) & 8'h33;
        n = 16'(rnd() % 4) + 16'h1;
        s = rnd();
        d = rnd();
        sel = ctl[`CTRL_DUAL] ? int'(w[3:0]) : int'(w[7:4]);
        wr(`OFF_WAIT, {24'h0, w});
        rd(`OFF_WAIT, v);
        chk(v, {24'h0, w});
        wr(`OFF_SRC, s);
        wr(`OFF_DST, d);
        wr(`OFF_COUNT, {16'h0, n});
        ack_cyc = 0;
        own_rise = 0;
        act_cyc = 0;
        wr_cyc = 0;
        pulse_mode <= ctl[`CTRL_EDGE];
        wr(`OFF_CTRL, ctl | 32'h3);
        req_on <= 1'b1;
        wait_te();
        req_on <= 1'b0;
        rd(`OFF_COUNT, v);
        chk(v, 32'h0);
        rd(`OFF_SRC, v);
        chk(v, s + n);
        rd(`OFF_DST, v);
        chk(v, ctl[`CTRL_DUAL] ? d + n : d);
        chk(32'(ack_cyc), 32'(n * (1 + sel)));
        chk(32'(act_cyc), 32'(n * (1 + sel) * (ctl[`CTRL_DUAL] ? 2 : 1)));
        chk(32'(wr_cyc), ctl[`CTRL_DUAL] ? 32'(n * (1 + sel)) : 32'h0);
        chk(a0, s);
        chk(32'(own_rise), ctl[`CTRL_BURST] ? 32'h1 : 32'(n));
        chk({31'h0, dma_end_interrupt}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`OFF_MASK, 32'h1);
        settle();
        chk({31'h0, irq}, 32'h1);
        wr(`OFF_STAT, 32'h1);
        wr(`OFF_MASK, 32'h0);
        wr(`OFF_CTRL, 32'h20);
        settle();
        chk({30'h0, irq, dma_end_interrupt}, 32'h0);
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog, far beyond the expected run length.
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    // ==========================================
    // Main sequence
    initial begin
        clk = 0; rst_n = 0; reg_addr = '0; reg_wdata = '0; reg_write = 0; reg_read = 0;
        nmi_event = 0; address_error = 0; req_on = 0; pulse_mode = 0; own_q = 0;
        seed = 32'h0000fa7d; error_cnt = 0; n_tests = 0; tick = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rst_a[i]) begin
            rd(rst_a[i], v);
            chk(v, 32'h0);
        end
        wr(8'h20, rnd());
        rd(8'h20, v);
        chk(v, 32'h0);
        wr(`OFF_OPER, 32'h1);
        foreach (modes[i]) run(modes[i]);
        // Edge mode with the pin held low: only one unit may go.
        wr(`OFF_COUNT, 32'h2);
        wr(`OFF_CTRL, 32'h13);
        pulse_mode <= 1'b0;
        req_on <= 1'b1;
        repeat (60) @(posedge clk);
        rd(`OFF_COUNT, v);
        chk(v, 32'h1);
        req_on <= 1'b0;
        wr(`OFF_CTRL, 32'h0);
        // Halts: channel enable clear, master enable clear, NMI with restart.
        for (int k = 0; k < 3; k++) begin
            wr(`OFF_WAIT, 32'hf0);
            wr(`OFF_COUNT, 32'h4);
            wr(`OFF_CTRL, 32'h7);
            req_on <= 1'b1;
            wait_ack();
            if (k == 0) wr(`OFF_CTRL, 32'h6);
            else if (k == 1) wr(`OFF_OPER, 32'h0);
            else begin
                nmi_event <= 1'b1;
                @(posedge clk);
                nmi_event <= 1'b0;
            end
            repeat (24) @(posedge clk);
            chk({31'h0, bus_own}, 32'h0);
            rd(`OFF_CTRL, v);
            chk({31'h0, v[`CTRL_TE]}, 32'h0);
            rd(`OFF_OPER, v);
            chk(v, k == 2 ? 32'h3 : (k == 1 ? 32'h0 : 32'h1));
            rd(`OFF_COUNT, v);
            chk(v, k == 1 ? 32'h3 : 32'h4);
            if (k == 2) begin
                wr(`OFF_OPER, 32'h3);
                wait_te();
                rd(`OFF_COUNT, v);
                chk(v, 32'h0);
            end
            req_on <= 1'b0;
            wr(`OFF_OPER, 32'h1);
            wr(`OFF_CTRL, 32'h20);
        end
        // Address error in a dual read: the write still completes.
        s = rnd();
        d = rnd();
        wr(`OFF_WAIT, 32'h03);
        wr(`OFF_SRC, s);
        wr(`OFF_DST, d);
        wr(`OFF_COUNT, 32'h3);
        wr(`OFF_CTRL, 32'hb);
        req_on <= 1'b1;
        wait_ack();
        address_error <= 1'b1;
        @(posedge clk);
        address_error <= 1'b0;
        repeat (30) @(posedge clk);
        req_on <= 1'b0;
        rd(`OFF_OPER, v);
        chk(v, 32'h5);
        rd(`OFF_COUNT, v);
        chk(v, 32'h2);
        rd(`OFF_SRC, v);
        chk(v, s + 1);
        rd(`OFF_DST, v);
        chk(v, d + 1);
        wr(`OFF_OPER, 32'h5);
        wr(`OFF_CTRL, 32'h0);
        // Burst level: lifting the request gives the bus back early.
        wr(`OFF_WAIT, 32'h30);
        wr(`OFF_COUNT, 32'h4);
        wr(`OFF_CTRL, 32'h7);
        req_on <= 1'b1;
        wait_ack();
        req_on <= 1'b0;
        repeat (40) @(posedge clk);
        chk({31'h0, bus_own}, 32'h0);
        rd(`OFF_COUNT, v);
        chk({31'h0, v == 32'h2 || v == 32'h3}, 32'h1);
        give_verdict();
    end
endmodule
